// >>> zbt_cfg_reg.sv
`timescale 1ns/1ps
`include "zbt_defs.svh"

// one zone configuration word with reserved bits forced to zero
module zbt_cfg_reg (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  // write port
  input  wire logic              wr_en_i,
  input  wire logic [15:0]       wr_data_i,
  // contents
  output logic [15:0]            value_o,
  output zbt_pkg::zbt_cfg_t      cfg_o
);
  import zbt_pkg::*;

  logic [15:0] cfg_q;

  // reset load and masked write
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cfg_q <= `ZBT_CFG_RESET;
    end else if (wr_en_i) begin
      cfg_q <= wr_data_i & `ZBT_CFG_WMASK;
    end
  end

  // field split
  assign value_o                = cfg_q;
  assign cfg_o.wait_cnt         = cfg_q[`ZBT_WAIT_MSB:`ZBT_WAIT_LSB];
  assign cfg_o.hold             = cfg_q[`ZBT_HOLD_MSB:`ZBT_HOLD_LSB];
  assign cfg_o.read_burst_enable = cfg_q[`ZBT_RBE_BIT];
  assign cfg_o.burst_read_wait  = cfg_q[`ZBT_WBR_BIT];
  assign cfg_o.bus_width_sel    = cfg_q[`ZBT_BW_BIT];
  assign cfg_o.post_idle_enable = cfg_q[`ZBT_POST_IDLE_ENABLE_BIT];
  assign cfg_o.pre_idle_enable  = cfg_q[`ZBT_PRE_IDLE_ENABLE_BIT];
  assign cfg_o.fast_read_enable = cfg_q[`ZBT_FRE_BIT];

endmodule : zbt_cfg_reg

// >>> zbt_checker.sv
`timescale 1ns/1ps
`include "zbt_defs.svh"

// ****************************************
// port checker against a shadow of the zone words
// ****************************************
module zbt_checker (
  // clock and reset
  input wire logic              core_clk_i,
  input wire logic              reset_i,
  // apb
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [11:0]       paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  // core and memory side
  input wire zbt_pkg::zbt_req_t core_cmd_i,
  input wire logic              core_done_o,
  input wire logic              mem_access_o,
  input wire logic              mem_wait_o,
  input wire logic              mem_hold_o,
  input wire logic              mem_burst_o,
  input wire logic              mem_wide_o,
  input wire logic              zone1_select_out_o,
  input wire logic              io_select_o,
  input wire logic              zone0_select_o
);
  import zbt_pkg::*;
  logic [15:0] sh_q [3];
  logic [1:0]  hold_cnt_q;
  logic [15:0] act;
  logic [1:0]  exp_hold;

  // shadow follows apb writes, masked so reserved bits stay zero
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (reset_i) begin
        sh_q[i] <= `ZBT_CFG_RESET;
      end else if (psel_i && penable_i && pwrite_i && paddr_i == 12'(4 * i)) begin
        sh_q[i] <= pwdata_i[15:0] & `ZBT_CFG_WMASK;
      end
    end
  end

  // word of the zone now selected; fast read drops holds on static zones
  assign act = io_select_o ? sh_q[0] : (zone0_select_o ? sh_q[1] : sh_q[2]);
  assign exp_hold = (act[11] && !io_select_o) ? 2'h0 : act[4:3];

  // run length of consecutive hold clocks
  always_ff @(posedge core_clk_i) begin
    if (reset_i || !mem_hold_o) begin
      hold_cnt_q <= 2'h0;
    end else begin
      hold_cnt_q <= hold_cnt_q + 2'h1;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_acc;
    psel_i && penable_i;
  endsequence
  sequence s_cfg_rd;
    s_acc ##0 (!pwrite_i && paddr_i < 12'h00c);
  endsequence

  a_apb_ready: assert property (s_acc |-> pready_o)
    else $error("apb access phase without ready");
  a_reg_readback: assert property (
    s_cfg_rd |-> prdata_o == {16'h0, sh_q[paddr_i[3:2]]})
    else $error("zone word read back wrong");
  a_reserved_zero: assert property (
    s_cfg_rd |-> (prdata_o & ~32'h0eff) == 32'h0)
    else $error("reserved bits not zero");
  a_unmapped_err: assert property (s_acc ##0 (paddr_i > 12'h00c) |-> pslverr_o)
    else $error("unmapped access without error");
  a_io_window: assert property (
    mem_access_o && io_select_o |-> core_cmd_i.addr[23:8] == 16'hfffb)
    else $error("io select outside io window");
  a_zone1_window: assert property (
    mem_access_o && zone1_select_out_o |-> core_cmd_i.addr[23:22] == 2'h1)
    else $error("zone 1 select outside zone 1");
  a_width_follows: assert property (mem_access_o |-> mem_wide_o == act[7])
    else $error("bus width differs from zone word");
  a_hold_bound: assert property (mem_hold_o |-> hold_cnt_q < exp_hold)
    else $error("too many hold clocks");
  a_fast_no_wait: assert property (
    mem_wait_o && !io_select_o && act[11] |-> core_cmd_i.write)
    else $error("wait clock in a fast read");
  a_fast_read_one: assert property (
    mem_access_o && !io_select_o && act[11] && !core_cmd_i.write |-> core_done_o)
    else $error("fast read longer than one clock");
  a_burst_cause: assert property (
    mem_burst_o && mem_access_o |-> !core_cmd_i.write && core_cmd_i.wide && !zone0_select_o)
    else $error("burst on a wrong access");
  a_normal_read_two: assert property (
    mem_access_o && !core_cmd_i.write && !mem_burst_o && !(act[11] && !io_select_o)
    |-> !core_done_o)
    else $error("normal read shorter than two clocks");
endmodule : zbt_checker

bind zbt_top zbt_checker u_zbt_checker (.*);

// >>> zbt_core_model.sv
`timescale 1ns/1ps

// ****************************************
// core bus master model
// ****************************************
module zbt_core_model (
  // clock
  input  wire logic         core_clk_i,
  // answers from the block
  input  wire logic         core_done_i,
  input  wire logic         mem_wide_i,
  // request to the block
  output zbt_pkg::zbt_req_t core_cmd_o,
  output logic              core_req_o
);
  import zbt_pkg::*;

  // idle until the first request
  initial begin
    core_req_o = 1'b0;
    core_cmd_o = '0;
  end

  // called just after a rising edge; n counts clocks from take to done
  task automatic run(input zbt_req_t c, output logic [7:0] n, output logic w);
    n = 8'h0;
    core_req_o <= 1'b1;
    core_cmd_o <= c;
    @(posedge core_clk_i);
    do begin
      @(negedge core_clk_i);
      n = n + 8'h1;
    end while (core_done_i !== 1'b1 && n < 8'h40);
    w = mem_wide_i;
    @(posedge core_clk_i);
    // a released command must not keep looking valid
    core_req_o <= 1'b0;
    core_cmd_o <= ~c;
    @(posedge core_clk_i);
  endtask : run
endmodule : zbt_core_model

// >>> zbt_defs.svh
`ifndef ZBT_DEFS_SVH
`define ZBT_DEFS_SVH

// ****************************************************************
// register map (byte addresses on the apb)
// ****************************************************************
`define ZBT_IO_CFG_ADDR     12'h000
`define ZBT_Z0_CFG_ADDR     12'h004
`define ZBT_Z1_CFG_ADDR     12'h008
`define ZBT_STATUS_ADDR     12'h00c

// ****************************************************************
// reset value and field positions
// ****************************************************************
`define ZBT_CFG_RESET       16'h069f
`define ZBT_CFG_WMASK       16'h0eff
`define ZBT_WAIT_LSB        0
`define ZBT_WAIT_MSB        2
`define ZBT_HOLD_LSB        3
`define ZBT_HOLD_MSB        4
`define ZBT_RBE_BIT         5
`define ZBT_WBR_BIT         6
`define ZBT_BW_BIT          7
`define ZBT_POST_IDLE_ENABLE_BIT        9
`define ZBT_PRE_IDLE_ENABLE_BIT        10
`define ZBT_FRE_BIT         11

// ****************************************************************
// address windows (24-bit core address)
// ****************************************************************
`define ZBT_IO_BASE         24'hfffb00
`define ZBT_IO_LAST         24'hfffbff
`define ZBT_Z1_BASE         24'h400000
`define ZBT_Z1_LAST         24'h7fffff

// ****************************************************************
// timing counts in clock cycles
// ****************************************************************
`define ZBT_BASE_CYCLES     4'h1
`define ZBT_IDLE_CYCLES    4'h1

`endif

// >>> zbt_pkg.sv
package zbt_pkg;

  // zone that a core access falls into
  typedef enum logic [1:0] {
    ZBT_ZONE_NONE,
    ZBT_ZONE_IO,
    ZBT_ZONE_0,
    ZBT_ZONE_1
  } zbt_zone_t;

  // decoded zone configuration word
  typedef struct packed {
    logic       fast_read_enable;
    logic       pre_idle_enable;
    logic       post_idle_enable;
    logic       bus_width_sel;
    logic       burst_read_wait;
    logic       read_burst_enable;
    logic [1:0] hold;
    logic [2:0] wait_cnt;
  } zbt_cfg_t;

  // core request
  typedef struct packed {
    logic [23:0] addr;
    logic        write;
    logic        wide;
  } zbt_req_t;

  // cycle plan handed to the sequencer
  typedef struct packed {
    logic [3:0] waits;
    logic [1:0] holds;
    logic       burst;
    logic       burst_wait;
    logic       pre_idle;
    logic       post_idle;
    logic       wide_bus;
  } zbt_plan_t;

endpackage : zbt_pkg

// >>> zbt_planner.sv
`timescale 1ns/1ps
`include "zbt_defs.svh"

// turns a zone configuration and access type into a cycle plan
module zbt_planner (
  // access description
  input  wire logic              is_zone0_i,
  input  wire logic              is_zone1_i,
  input  wire logic              write_i,
  input  wire logic              wide_i,
  input  zbt_pkg::zbt_cfg_t      cfg_i,
  // result
  output zbt_pkg::zbt_plan_t     plan_o
);
  import zbt_pkg::*;

  logic fast;
  logic burst_ok;

  // fast read only applies to the two static zones
  assign fast = cfg_i.fast_read_enable & (is_zone0_i | is_zone1_i);

  // burst: 16-bit read on 8-bit bus; never on zone 0; zone 1 needs bw set
  assign burst_ok = !write_i && wide_i && !fast && !is_zone0_i
                    && cfg_i.read_burst_enable
                    && (!is_zone1_i || cfg_i.bus_width_sel)
                    && (is_zone1_i || !cfg_i.bus_width_sel);

  always_comb begin
    plan_o = '0;
    plan_o.wide_bus = cfg_i.bus_width_sel;
    plan_o.pre_idle = cfg_i.pre_idle_enable;
    plan_o.post_idle = cfg_i.post_idle_enable;
    plan_o.burst = burst_ok;
    plan_o.burst_wait = burst_ok & cfg_i.burst_read_wait;
    if (fast) begin
      // wait and hold fields ignored under fast read
      plan_o.waits = write_i ? 4'h1 : 4'h0;
      plan_o.holds = 2'h0;
    end else if (!write_i) begin
      // a normal read keeps its second base clock so it never matches a fast one
      plan_o.waits = {1'b0, cfg_i.wait_cnt} + `ZBT_BASE_CYCLES;
      plan_o.holds = cfg_i.hold;
    end else begin
      plan_o.waits = {1'b0, cfg_i.wait_cnt};
      plan_o.holds = cfg_i.hold;
    end
  end

endmodule : zbt_planner

// >>> zbt_top.sv
`timescale 1ns/1ps
`include "zbt_defs.svh"

module zbt_top (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [11:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // core bus request
  input  wire logic              core_req_i,
  input  wire zbt_pkg::zbt_req_t core_cmd_i,
  output logic                   core_done_o,
  // memory side strobes
  output logic                   mem_cycle_o,
  output logic                   mem_access_o,
  output logic                   mem_wait_o,
  output logic                   mem_hold_o,
  output logic                   mem_idle_o,
  output logic                   mem_burst_o,
  output logic                   mem_wide_o,
  output logic                   zone1_select_out_o,
  output logic                   io_select_o,
  output logic                   zone0_select_o
);
  import zbt_pkg::*;

  // ****************************************************************
  // zone decode
  // ****************************************************************

  zbt_zone_t zone_now;

  // flash and its data memory map to zone 0, i/o window and zone 1 by range
  always_comb begin
    if (core_cmd_i.addr >= `ZBT_IO_BASE && core_cmd_i.addr <= `ZBT_IO_LAST) begin
      zone_now = ZBT_ZONE_IO;
    end else if (core_cmd_i.addr >= `ZBT_Z1_BASE && core_cmd_i.addr <= `ZBT_Z1_LAST) begin
      zone_now = ZBT_ZONE_1;
    end else if (core_cmd_i.addr < 24'h040000 ||
                 (core_cmd_i.addr >= 24'h0d0000 && core_cmd_i.addr < 24'h0d2000)) begin
      zone_now = ZBT_ZONE_0;
    end else begin
      zone_now = ZBT_ZONE_NONE;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************

  logic        apb_wr;
  logic [15:0] io_val;
  logic [15:0] z0_val;
  logic [15:0] z1_val;
  zbt_cfg_t    io_cfg;
  zbt_cfg_t    z0_cfg;
  zbt_cfg_t    z1_cfg;

  // one-cycle access phase: writes land on the edge that ends it
  assign apb_wr = psel_i & penable_i & pwrite_i;

  zbt_cfg_reg u_io_cfg (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .wr_en_i    (apb_wr && paddr_i == `ZBT_IO_CFG_ADDR),
    .wr_data_i  (pwdata_i[15:0]),
    .value_o    (io_val),
    .cfg_o      (io_cfg)
  );

  zbt_cfg_reg u_z0_cfg (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .wr_en_i    (apb_wr && paddr_i == `ZBT_Z0_CFG_ADDR),
    .wr_data_i  (pwdata_i[15:0]),
    .value_o    (z0_val),
    .cfg_o      (z0_cfg)
  );

  zbt_cfg_reg u_z1_cfg (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .wr_en_i    (apb_wr && paddr_i == `ZBT_Z1_CFG_ADDR),
    .wr_data_i  (pwdata_i[15:0]),
    .value_o    (z1_val),
    .cfg_o      (z1_cfg)
  );

  // ****************************************************************
  // cycle planning
  // ****************************************************************

  zbt_cfg_t  sel_cfg;
  zbt_plan_t plan;

  // pick the register that governs the addressed zone
  always_comb begin
    case (zone_now)
      ZBT_ZONE_IO: sel_cfg = io_cfg;
      ZBT_ZONE_0:  sel_cfg = z0_cfg;
      ZBT_ZONE_1:  sel_cfg = z1_cfg;
      default:     sel_cfg = '0;
    endcase
  end

  zbt_planner u_planner (
    .is_zone0_i (zone_now == ZBT_ZONE_0),
    .is_zone1_i (zone_now == ZBT_ZONE_1),
    .write_i    (core_cmd_i.write),
    .wide_i     (core_cmd_i.wide),
    .cfg_i      (sel_cfg),
    .plan_o     (plan)
  );

  // ****************************************************************
  // bus cycle sequencer
  // ****************************************************************

  typedef enum {
    ST_IDLE,
    ST_PRE,
    ST_ACCESS,
    ST_WAIT,
    ST_BURST,
    ST_HOLD,
    ST_POST
  } zbt_state_t;

  zbt_state_t state_q;
  zbt_plan_t  plan_q;
  zbt_zone_t  zone_q;
  zbt_zone_t  last_zone_q;
  logic       post_pending_q;
  logic [3:0] cnt_q;
  logic       burst_half_q;
  logic       zone_change;

  // a different zone from the previous bus cycle triggers idle handling
  assign zone_change = (zone_now != last_zone_q);

  // main sequence; the access cycle itself is the first clock, so a fast
  // read with no extra cycles finishes in one clock
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_q      <= ST_IDLE;
      plan_q       <= '0;
      zone_q       <= ZBT_ZONE_NONE;
      cnt_q        <= 4'h0;
      burst_half_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (core_req_i && zone_now != ZBT_ZONE_NONE) begin
            plan_q       <= plan;
            zone_q       <= zone_now;
            burst_half_q <= 1'b0;
            if (zone_change && post_pending_q) begin
              state_q <= ST_POST;
            end else if (zone_change && plan.pre_idle) begin
              state_q <= ST_PRE;
            end else begin
              state_q <= ST_ACCESS;
            end
          end
        end
        ST_POST: begin
          // pre-idle of the new cycle still applies after the post idle
          state_q <= plan_q.pre_idle ? ST_PRE : ST_ACCESS;
        end
        ST_PRE: begin
          state_q <= ST_ACCESS;
        end
        ST_ACCESS: begin
          cnt_q <= 4'h0;
          if (plan_q.waits != 4'h0) begin
            state_q <= ST_WAIT;
          end else if (plan_q.burst && !burst_half_q) begin
            state_q <= plan_q.burst_wait ? ST_BURST : ST_ACCESS;
            burst_half_q <= 1'b1;
          end else if (plan_q.holds != 2'h0) begin
            state_q <= ST_HOLD;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (cnt_q + 4'h1 >= plan_q.waits) begin
            cnt_q <= 4'h0;
            if (plan_q.burst && !burst_half_q) begin
              state_q <= plan_q.burst_wait ? ST_BURST : ST_ACCESS;
              plan_q.waits <= 4'h0;
              burst_half_q <= 1'b1;
            end else if (plan_q.holds != 2'h0) begin
              state_q <= ST_HOLD;
            end else begin
              state_q <= ST_IDLE;
            end
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        ST_BURST: begin
          // one burst wait cycle before the second byte
          state_q <= ST_ACCESS;
        end
        ST_HOLD: begin
          if (cnt_q + 4'h1 >= {2'b00, plan_q.holds}) begin
            cnt_q   <= 4'h0;
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // last zone and pending post-idle, updated as each cycle ends
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      last_zone_q    <= ZBT_ZONE_NONE;
      post_pending_q <= 1'b0;
    end else if (core_done_o) begin
      last_zone_q    <= zone_q;
      post_pending_q <= plan_q.post_idle;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  // done marks the last clock of a bus cycle
  always_comb begin
    core_done_o = 1'b0;
    case (state_q)
      ST_ACCESS: core_done_o = (plan_q.waits == 4'h0) && (plan_q.holds == 2'h0) &&
                               !(plan_q.burst && !burst_half_q);
      ST_WAIT:   core_done_o = (cnt_q + 4'h1 >= plan_q.waits) && (plan_q.holds == 2'h0) &&
                               !(plan_q.burst && !burst_half_q);
      ST_HOLD:   core_done_o = (cnt_q + 4'h1 >= {2'b00, plan_q.holds});
      default:   core_done_o = 1'b0;
    endcase
  end

  assign mem_cycle_o        = (state_q != ST_IDLE);
  assign mem_access_o       = (state_q == ST_ACCESS);
  assign mem_wait_o         = (state_q == ST_WAIT) || (state_q == ST_BURST);
  assign mem_hold_o         = (state_q == ST_HOLD);
  assign mem_idle_o         = (state_q == ST_PRE) || (state_q == ST_POST);
  assign mem_burst_o        = (state_q != ST_IDLE) && plan_q.burst;
  assign mem_wide_o         = plan_q.wide_bus;
  assign zone1_select_out_o = (state_q != ST_IDLE) && (zone_q == ZBT_ZONE_1);
  assign io_select_o        = (state_q != ST_IDLE) && (zone_q == ZBT_ZONE_IO);
  assign zone0_select_o     = (state_q != ST_IDLE) && (zone_q == ZBT_ZONE_0);

  // ****************************************************************
  // apb read path
  // ****************************************************************

  logic [31:0] rdata_q;

  // read data registered in the setup cycle, ready in the access phase
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      case (paddr_i)
        `ZBT_IO_CFG_ADDR: rdata_q <= {16'h0000, io_val};
        `ZBT_Z0_CFG_ADDR: rdata_q <= {16'h0000, z0_val};
        `ZBT_Z1_CFG_ADDR: rdata_q <= {16'h0000, z1_val};
        `ZBT_STATUS_ADDR: rdata_q <= {24'h000000, 1'b0, core_done_o,
                                      mem_cycle_o, 1'b0, 2'(zone_q), 2'(last_zone_q)};
        default:          rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata_o  = rdata_q;
  assign pready_o  = 1'b1;
  // unmapped addresses answer with an error, status is read only
  assign pslverr_o = psel_i && penable_i &&
                     !(paddr_i == `ZBT_IO_CFG_ADDR || paddr_i == `ZBT_Z0_CFG_ADDR ||
                       paddr_i == `ZBT_Z1_CFG_ADDR ||
                       (paddr_i == `ZBT_STATUS_ADDR && !pwrite_i));

endmodule : zbt_top

// >>> zbt_top_tb.sv
`timescale 1ns/1ps
`include "zbt_defs.svh"

// ****************************************
// zone timing testbench
// ****************************************
module zbt_top_tb;
  import zbt_pkg::*;
  localparam logic [23:0] A_IO = 24'hfffb10;
  localparam logic [23:0] A_Z0 = 24'h001000;
  localparam logic [23:0] A_Z1 = 24'h400100;
  logic        core_clk_i, reset_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic        pready_o, pslverr_o, core_req_i, core_done_o, mem_cycle_o;
  zbt_req_t    core_cmd_i;
  logic        mem_access_o, mem_wait_o, mem_hold_o, mem_idle_o, mem_burst_o;
  logic        mem_wide_o, zone1_select_out_o, io_select_o, zone0_select_o;
  logic [7:0]  ln;
  logic        lw;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;

  zbt_top u_zbt_top (.*);
  zbt_core_model u_zbt_core_model (
    .core_clk_i (core_clk_i),
    .core_done_i(core_done_o),
    .mem_wide_i (mem_wide_o),
    .core_cmd_o (core_cmd_i),
    .core_req_o (core_req_i)
  );

  // free running clock
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // a hang counts as a mismatch
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int k;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    chk(nm, r, exp);
  endtask : rd_chk

  // one core cycle, judged by its length in clocks
  task automatic acc(input logic [23:0] a, input logic w, input logic wd, input logic [7:0] e);
    u_zbt_core_model.run(zbt_req_t'({a, w, wd}), ln, lw);
    chk("core cycles", {24'h0, ln}, {24'h0, e});
  endtask : acc

  task automatic t_regs();
    logic [31:0] d;
    logic e;
    rd_chk(`ZBT_IO_CFG_ADDR, 32'h069f, "io cfg");
    rd_chk(`ZBT_Z0_CFG_ADDR, 32'h069f, "z0 cfg");
    rd_chk(`ZBT_Z1_CFG_ADDR, 32'h069f, "z1 cfg");
    for (int i = 0; i < 3; i++) begin
      wr(12'(4 * i), 32'hffffffff);
      rd_chk(12'(4 * i), 32'h0eff, "masked cfg");
      wr(12'(4 * i), 32'h0000f100);
      rd_chk(12'(4 * i), 32'h0, "reserved cfg");
    end
    apb(12'h010, 1'b0, 32'h0, d, e);
    chk("unmapped err", {31'h0, e}, 32'h1);
    apb(`ZBT_STATUS_ADDR, 1'b1, 32'h3f, d, e);
    chk("status write err", {31'h0, e}, 32'h1);
  endtask : t_regs

  task automatic t_io();
    for (int w = 0; w < 8; w += 7) begin
      for (int h = 0; h < 4; h += 3) begin
        wr(`ZBT_IO_CFG_ADDR, 32'(8'h80 | (h << 3) | w));
        acc(A_IO, 1'b0, 1'b1, 8'(2 + w + h));
        acc(A_IO, 1'b1, 1'b1, 8'(1 + w + h));
      end
    end
    chk("wide bus", {31'h0, lw}, 32'h1);
    wr(`ZBT_IO_CFG_ADDR, 32'h0000);
    acc(A_IO, 1'b0, 1'b0, 8'd2);
    chk("narrow bus", {31'h0, lw}, 32'h0);
    wr(`ZBT_IO_CFG_ADDR, 32'h0020);
    acc(A_IO, 1'b0, 1'b1, 8'd3);
    wr(`ZBT_IO_CFG_ADDR, 32'h0060);
    acc(A_IO, 1'b0, 1'b1, 8'd4);
    acc(A_IO, 1'b1, 1'b1, 8'd1);
  endtask : t_io

  // zone 0 stays 16-bit with idle bits clear
  task automatic t_zone0();
    wr(`ZBT_Z0_CFG_ADDR, 32'h00fb);
    acc(A_Z0, 1'b0, 1'b1, 8'd8);
    acc(A_Z0, 1'b1, 1'b1, 8'd7);
    wr(`ZBT_Z0_CFG_ADDR, 32'h08fb);
    acc(A_Z0, 1'b0, 1'b1, 8'd1);
    acc(A_Z0, 1'b1, 1'b1, 8'd2);
  endtask : t_zone0

  task automatic t_zone1();
    wr(`ZBT_Z1_CFG_ADDR, 32'h0092);
    acc(A_Z1, 1'b0, 1'b0, 8'd6);
    acc(A_Z1, 1'b0, 1'b1, 8'd6);
    wr(`ZBT_Z1_CFG_ADDR, 32'h00b2);
    acc(A_Z1, 1'b0, 1'b1, 8'd7);
    wr(`ZBT_Z1_CFG_ADDR, 32'h00f2);
    acc(A_Z1, 1'b0, 1'b1, 8'd8);
    wr(`ZBT_Z1_CFG_ADDR, 32'h0072);
    acc(A_Z1, 1'b0, 1'b1, 8'd6);
    wr(`ZBT_Z1_CFG_ADDR, 32'h08f2);
    acc(A_Z1, 1'b0, 1'b1, 8'd1);
    acc(A_Z1, 1'b1, 1'b1, 8'd2);
  endtask : t_zone1

  task automatic t_idle();
    wr(`ZBT_IO_CFG_ADDR, 32'h0080);
    wr(`ZBT_Z1_CFG_ADDR, 32'h0480);
    acc(A_IO, 1'b0, 1'b1, 8'd2);
    acc(A_Z1, 1'b0, 1'b1, 8'd3);
    acc(A_Z1, 1'b0, 1'b1, 8'd2);
    wr(`ZBT_Z1_CFG_ADDR, 32'h0280);
    acc(A_Z1, 1'b0, 1'b1, 8'd2);
    acc(A_IO, 1'b0, 1'b1, 8'd3);
    wr(`ZBT_Z1_CFG_ADDR, 32'h0080);
    acc(A_Z1, 1'b0, 1'b1, 8'd2);
  endtask : t_idle

  // reset for 8 clocks, then each scenario in turn
  initial begin
    reset_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    repeat (8) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    t_regs();
    t_io();
    t_zone0();
    t_zone1();
    t_idle();
    end_sim();
  end
endmodule : zbt_top_tb
